// ---- mdsc_top.sv ----
// two-channel monitor DAC path: data select, gain, offset code, registers
`timescale 1ns/1ps
module mdsc_top #(
    parameter int TICK_CYCLES = mdsc_pkg::SAMPLE_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire mdsc_pkg::mdsc_quant_t QUANT,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [7:0] DAC1_CODE,
    output logic [7:0] DAC2_CODE,
    output logic DAC_UPDATE
);
    mdsc_pkg::mdsc_cfg_t cfg_reg;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [23:0] tick_cnt_reg;
    logic tick;
    logic [15:0] out4_word;
    logic signed [31:0] speedo_val;
    logic signed [31:0] load_val;
    logic signed [31:0] ch1_val;
    logic signed [31:0] ch2_val;

    // unsigned magnitude of a signed quantity
    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction : mag

    // meter scaling: zero maps to code -128, full maps to +127
    function automatic logic signed [31:0] meter(input logic [31:0] m,
                                                 input logic [31:0] full);
        logic [39:0] num;
        logic [39:0] q;
        num = 40'(m) * 40'(mdsc_pkg::METER_SPAN);
        q = num / 40'((full == 32'h0) ? 32'h1 : full);
        meter = $signed(q[31:0]) - mdsc_pkg::METER_OFFSET;
    endfunction : meter

    // data-number decode shared by both channels
    function automatic logic signed [31:0] pick(input logic [6:0] dn,
                                                input mdsc_pkg::mdsc_quant_t q,
                                                input logic [15:0] out4,
                                                input logic signed [31:0] mtr);
        logic [6:0] rel;
        rel = dn - mdsc_pkg::DN_CTRL_IN1;
        case (dn)
            mdsc_pkg::DN_METER: pick = mtr;
            mdsc_pkg::DN_CUR_CMD: pick = 32'(q.current_cmd);
            mdsc_pkg::DN_CUR_FB: pick = 32'(q.current_fb);
            mdsc_pkg::DN_SPEED_FB: pick = q.speed_fb;
            mdsc_pkg::DN_DROOP_LO: pick = {16'h0000, q.droop[15:0]};
            mdsc_pkg::DN_DROOP_HI: pick = 32'($signed(q.droop[31:16]));
            mdsc_pkg::DN_INCR_LO: pick = {16'h0000, q.pos_incr[15:0]};
            mdsc_pkg::DN_INCR_HI: pick = 32'($signed(q.pos_incr[31:16]));
            mdsc_pkg::DN_PCMD_LO: pick = {16'h0000, q.pos_cmd[15:0]};
            mdsc_pkg::DN_PCMD_HI: pick = 32'($signed(q.pos_cmd[31:16]));
            mdsc_pkg::DN_FBPOS_LO: pick = {16'h0000, q.fb_pos[15:0]};
            mdsc_pkg::DN_FBPOS_HI: pick = 32'($signed(q.fb_pos[31:16]));
            default: begin
                if (dn >= mdsc_pkg::DN_CTRL_IN1 && dn <= mdsc_pkg::DN_CTRL_IN4) begin
                    pick = {16'h0000, q.ctrl_in[rel[1:0]]};
                end else if (dn >= mdsc_pkg::DN_CTRL_OUT1 && dn < mdsc_pkg::DN_CTRL_OUT4) begin
                    pick = {16'h0000, q.ctrl_out[rel[1:0]]};
                end else if (dn == mdsc_pkg::DN_CTRL_OUT4) begin
                    pick = {16'h0000, out4};
                end else begin
                    pick = 32'sh0000_0000;
                end
            end
        endcase
    endfunction : pick

    // sample tick divider, one pulse every TICK_CYCLES clocks
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tick_cnt_reg <= 24'h00_0000;
        end else if (tick) begin
            tick_cnt_reg <= 24'h00_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 24'h00_0001;
        end
    end
    assign tick = (tick_cnt_reg == 24'(TICK_CYCLES - 1));

    // update strobe registered from tick, high in the same cycle the code registers change
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            DAC_UPDATE <= 1'b0;
        end else begin
            DAC_UPDATE <= tick;
        end
    end

    // control output word 4 with orientation and indexing complete bits
    always_comb begin
        out4_word = QUANT.ctrl_out[3];
        out4_word[mdsc_pkg::ORIENT_BIT] = QUANT.orient_done;
        out4_word[mdsc_pkg::INDEX_BIT] = QUANT.orient_done;
    end

    // meters and per-channel selection
    always_comb begin
        speedo_val = meter(mag(QUANT.speed_fb),
                           {16'h0000, cfg_reg.speedometer_full_scale_speed});
        load_val = meter(mag(32'(QUANT.load)), mdsc_pkg::LOAD_FULL_SCALE);
        ch1_val = pick(cfg_reg.first_channel_selector, QUANT, out4_word, speedo_val);
        ch2_val = pick(cfg_reg.second_channel_selector, QUANT, out4_word, load_val);
    end

    mdsc_scaler u_ch1 (
        .clk(CLK),
        .rst(RST),
        .tick(tick),
        .value(ch1_val),
        .gain(cfg_reg.first_channel_multiplier),
        .code(DAC1_CODE)
    );

    mdsc_scaler u_ch2 (
        .clk(CLK),
        .rst(RST),
        .tick(tick),
        .value(ch2_val),
        .gain(cfg_reg.second_channel_multiplier),
        .code(DAC2_CODE)
    );

    // register write decode, byte lanes honoured
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg_reg.first_channel_selector <= mdsc_pkg::SEL_RESET;
            cfg_reg.second_channel_selector <= mdsc_pkg::SEL_RESET;
            cfg_reg.first_channel_multiplier <= mdsc_pkg::GAIN_RESET;
            cfg_reg.second_channel_multiplier <= mdsc_pkg::GAIN_RESET;
            cfg_reg.speedometer_full_scale_speed <= mdsc_pkg::SPEEDO_FS_RESET;
        end else if (wr_en) begin
            case (wr_addr)
                mdsc_pkg::ADDR_CH1_SEL: begin
                    if (wr_strb[0]) cfg_reg.first_channel_selector <= wr_data[6:0];
                end
                mdsc_pkg::ADDR_CH2_SEL: begin
                    if (wr_strb[0]) cfg_reg.second_channel_selector <= wr_data[6:0];
                end
                mdsc_pkg::ADDR_CH1_GAIN: begin
                    if (wr_strb[0]) cfg_reg.first_channel_multiplier[7:0] <= wr_data[7:0];
                    if (wr_strb[1]) cfg_reg.first_channel_multiplier[15:8] <= wr_data[15:8];
                end
                mdsc_pkg::ADDR_CH2_GAIN: begin
                    if (wr_strb[0]) cfg_reg.second_channel_multiplier[7:0] <= wr_data[7:0];
                    if (wr_strb[1]) cfg_reg.second_channel_multiplier[15:8] <= wr_data[15:8];
                end
                mdsc_pkg::ADDR_SPEEDO_FS: begin
                    if (wr_strb[0]) cfg_reg.speedometer_full_scale_speed[7:0] <= wr_data[7:0];
                    if (wr_strb[1]) cfg_reg.speedometer_full_scale_speed[15:8] <= wr_data[15:8];
                end
                default: begin
                end
            endcase
        end
    end

    // write acceptance and read mux
    always_comb begin
        wr_ok = (wr_addr == mdsc_pkg::ADDR_CH1_SEL) || (wr_addr == mdsc_pkg::ADDR_CH2_SEL) ||
                (wr_addr == mdsc_pkg::ADDR_CH1_GAIN) || (wr_addr == mdsc_pkg::ADDR_CH2_GAIN) ||
                (wr_addr == mdsc_pkg::ADDR_SPEEDO_FS);
        rd_ok = 1'b1;
        case (rd_addr)
            mdsc_pkg::ADDR_CH1_SEL: rd_data = {25'h0, cfg_reg.first_channel_selector};
            mdsc_pkg::ADDR_CH2_SEL: rd_data = {25'h0, cfg_reg.second_channel_selector};
            mdsc_pkg::ADDR_CH1_GAIN: rd_data = {16'h0, cfg_reg.first_channel_multiplier};
            mdsc_pkg::ADDR_CH2_GAIN: rd_data = {16'h0, cfg_reg.second_channel_multiplier};
            mdsc_pkg::ADDR_SPEEDO_FS: rd_data = {16'h0, cfg_reg.speedometer_full_scale_speed};
            mdsc_pkg::ADDR_STATUS: rd_data = {16'h0, DAC2_CODE, DAC1_CODE};
            default: begin
                rd_data = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    mdsc_axil u_axil (
        .clk(CLK),
        .rst(RST),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // codes hold between ticks
    codes_hold_a: assert property (@(posedge CLK) disable iff (RST)
        !tick |=> $stable(DAC1_CODE) && $stable(DAC2_CODE))
        else $error("code changed without a sample tick");

    // update pulse follows each tick and the divider restarts
    tick_period_a: assert property (@(posedge CLK) disable iff (RST)
        tick |=> DAC_UPDATE && !tick && tick_cnt_reg == 24'h00_0000)
        else $error("update pulse or divider restart wrong");

    // zero speed at unity gain gives mid-scale
    zero_mid_a: assert property (@(posedge CLK) disable iff (RST)
        tick && cfg_reg.first_channel_selector == mdsc_pkg::DN_SPEED_FB &&
        cfg_reg.first_channel_multiplier == 16'sh0000 && QUANT.speed_fb == 32'sh0
        |=> DAC1_CODE == 8'h80)
        else $error("zero value not mid-scale");

    // wrap instead of clamp: 200 r/min at unity gives 0x48
    wrap_code_a: assert property (@(posedge CLK) disable iff (RST)
        tick && cfg_reg.first_channel_selector == mdsc_pkg::DN_SPEED_FB &&
        cfg_reg.first_channel_multiplier == 16'sh0100 && QUANT.speed_fb == 32'sd200
        |=> DAC1_CODE == 8'h48)
        else $error("overrange did not wrap");

    // full-scale speedometer reaches top code
    speedo_full_a: assert property (@(posedge CLK) disable iff (RST)
        tick && cfg_reg.first_channel_selector == mdsc_pkg::DN_METER &&
        cfg_reg.first_channel_multiplier == 16'sh0000 &&
        QUANT.speed_fb == 32'(cfg_reg.speedometer_full_scale_speed)
        |=> DAC1_CODE == 8'hFF)
        else $error("speedometer full scale wrong");

    // 120 percent load reaches top code on channel 2
    load_full_a: assert property (@(posedge CLK) disable iff (RST)
        tick && cfg_reg.second_channel_selector == mdsc_pkg::DN_METER &&
        cfg_reg.second_channel_multiplier == 16'sh0000 && QUANT.load == 16'sh1333
        |=> DAC2_CODE == 8'hFF)
        else $error("load meter full scale wrong");

    // 4096 current at gain 1/256 gives +16
    current_scale_a: assert property (@(posedge CLK) disable iff (RST)
        tick && cfg_reg.second_channel_selector == mdsc_pkg::DN_CUR_FB &&
        cfg_reg.second_channel_multiplier == 16'sh0001 && QUANT.current_fb == 16'sh1000
        |=> DAC2_CODE == 8'h90)
        else $error("current scaling wrong");

    // orientation complete sets bits 4 and 7 together
    orient_bits_a: assert property (@(posedge CLK) disable iff (RST)
        cfg_reg.first_channel_selector == mdsc_pkg::DN_CTRL_OUT4
        |-> ch1_val[mdsc_pkg::ORIENT_BIT] == QUANT.orient_done &&
        ch1_val[mdsc_pkg::INDEX_BIT] == QUANT.orient_done)
        else $error("orientation bits not aligned");

    // high-order droop word is the upper half
    droop_high_a: assert property (@(posedge CLK) disable iff (RST)
        cfg_reg.first_channel_selector == mdsc_pkg::DN_DROOP_HI
        |-> ch1_val == {{16{QUANT.droop[31]}}, QUANT.droop[31:16]})
        else $error("droop high word wrong");
endmodule : mdsc_top

// ---- mdsc_pkg.sv ----
// constants and carrier types for the monitor DAC data scaler
package mdsc_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CH1_SEL = 8'h00;
    localparam logic [7:0] ADDR_CH2_SEL = 8'h04;
    localparam logic [7:0] ADDR_CH1_GAIN = 8'h08;
    localparam logic [7:0] ADDR_CH2_GAIN = 8'h0C;
    localparam logic [7:0] ADDR_SPEEDO_FS = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // values after reset
    localparam logic [6:0] SEL_RESET = 7'h00;
    localparam logic [15:0] GAIN_RESET = 16'h0000;
    localparam logic [15:0] SPEEDO_FS_RESET = 16'h1770;
    // data numbers
    localparam logic [6:0] DN_METER = 7'h00;
    localparam logic [6:0] DN_CUR_CMD = 7'h02;
    localparam logic [6:0] DN_CUR_FB = 7'h03;
    localparam logic [6:0] DN_SPEED_FB = 7'h04;
    localparam logic [6:0] DN_DROOP_LO = 7'h06;
    localparam logic [6:0] DN_DROOP_HI = 7'h07;
    localparam logic [6:0] DN_INCR_LO = 7'h08;
    localparam logic [6:0] DN_INCR_HI = 7'h09;
    localparam logic [6:0] DN_PCMD_LO = 7'h0A;
    localparam logic [6:0] DN_PCMD_HI = 7'h0B;
    localparam logic [6:0] DN_FBPOS_LO = 7'h0C;
    localparam logic [6:0] DN_FBPOS_HI = 7'h0D;
    localparam logic [6:0] DN_CTRL_IN1 = 7'h50;
    localparam logic [6:0] DN_CTRL_IN4 = 7'h53;
    localparam logic [6:0] DN_CTRL_OUT1 = 7'h54;
    localparam logic [6:0] DN_CTRL_OUT4 = 7'h57;
    // scaling
    localparam int GAIN_SHIFT = 8;
    localparam logic signed [15:0] GAIN_UNITY = 16'sh0100;
    localparam logic [7:0] DAC_MID = 8'h80;
    localparam logic [31:0] CURRENT_FULL = 32'h0000_1000;
    localparam logic [31:0] LOAD_FULL_SCALE = 32'h0000_1333;
    localparam logic [31:0] METER_SPAN = 32'h0000_00FF;
    localparam logic signed [31:0] METER_OFFSET = 32'sh0000_0080;
    localparam int ORIENT_BIT = 4;
    localparam int INDEX_BIT = 7;
    // output update period
    localparam int SAMPLE_PERIOD_NS = 444000;
    localparam int CLK_MHZ = 250;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS * CLK_MHZ / 1000;

    // internal drive quantities offered to the monitor
    typedef struct packed {
        logic signed [15:0] current_cmd;
        logic signed [15:0] current_fb;
        logic signed [15:0] load;
        logic signed [31:0] speed_fb;
        logic signed [31:0] droop;
        logic signed [31:0] pos_incr;
        logic signed [31:0] pos_cmd;
        logic signed [31:0] fb_pos;
        logic [3:0][15:0] ctrl_in;
        logic [3:0][15:0] ctrl_out;
        logic orient_done;
    } mdsc_quant_t;

    // software settings
    typedef struct packed {
        logic [6:0] first_channel_selector;
        logic [6:0] second_channel_selector;
        logic signed [15:0] first_channel_multiplier;
        logic signed [15:0] second_channel_multiplier;
        logic [15:0] speedometer_full_scale_speed;
    } mdsc_cfg_t;
endpackage : mdsc_pkg

// ---- mdsc_scaler.sv ----
// one channel: gain multiply, divide by 256, wrap to 8-bit offset code
`timescale 1ns/1ps
module mdsc_scaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic signed [31:0] value,
    input wire logic signed [15:0] gain,
    output logic [7:0] code
);
    logic signed [15:0] eff_gain;
    logic signed [47:0] product;
    logic signed [47:0] scaled;

    // zero gain means unity, then multiply and arithmetic shift by 8
    always_comb begin
        eff_gain = (gain == 16'sh0000) ? mdsc_pkg::GAIN_UNITY : gain;
        product = value * eff_gain;
        scaled = product >>> mdsc_pkg::GAIN_SHIFT;
    end

    // low byte kept (wrap, no clamp), sign bit flipped for mid-scale zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code <= mdsc_pkg::DAC_MID;
        end else if (tick) begin
            code <= scaled[7:0] ^ mdsc_pkg::DAC_MID;
        end
    end
endmodule : mdsc_scaler

// ---- mdsc_axil.sv ----
// AXI4-Lite slave handshake; register storage lives in the parent
`timescale 1ns/1ps
module mdsc_axil (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_got_reg;
    logic w_got_reg;
    logic rd_take;

    // write fires once both halves are held and no response is pending
    assign wr_en = aw_got_reg & w_got_reg & ~bvalid;
    assign rd_take = arvalid & arready;
    assign rd_addr = araddr;

    // write address and data captured in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_got_reg <= 1'b1;
                awready <= 1'b0;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_reg <= 1'b1;
                wready <= 1'b0;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_en) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
            end
            if (bvalid && bready) begin
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // write response, SLVERR for unmapped or read-only offsets
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else if (wr_en) begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? 2'h0 : 2'h2;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read channel: data registered at the address handshake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end else if (rd_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_ok ? rd_data : 32'h0000_0000;
            rresp <= rd_ok ? 2'h0 : 2'h2;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end
endmodule : mdsc_axil

// ---- mdsc_dac_model.sv ----
// behavioural 8-bit DAC at the far side: offset code to output millivolts
`timescale 1ns/1ps
module mdsc_dac_model (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] code,
    input wire logic update,
    output int mv
);
    // latch the code on each update pulse, code 0x80 sits at mid-scale
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mv <= 5000;
        end else if (update) begin
            mv <= int'(code) * 10000 / 256;
        end
    end
endmodule : mdsc_dac_model

// ---- monitor_dac_data_scaler_test.sv ----
// self-checking bench for the two-channel monitor DAC path
`timescale 1ns/1ps
module monitor_dac_data_scaler_test;
    localparam int TICKS = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mdsc_pkg::mdsc_quant_t q = '0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, upd;
    logic [1:0] bresp, rresp, r;
    logic [7:0] c1, c2;
    int mv, n, n_mismatch = 0, checks = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    mdsc_top #(.TICK_CYCLES(TICKS)) DUT (.CLK(clk), .RST(rst), .QUANT(q),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .DAC1_CODE(c1),
        .DAC2_CODE(c2), .DAC_UPDATE(upd));
    mdsc_dac_model DAC (.CLK(clk), .RST(rst), .code(c1), .update(upd), .mv(mv));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // expected offset code: gain, divide by 256, keep low byte, flip sign bit
    function automatic logic [7:0] xc(input int v, input int g);
        int p;
        p = v * (g == 0 ? 256 : g);
        return p[15:8] ^ 8'h80;
    endfunction : xc
    // AXI4-Lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    // AXI4-Lite read
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd
    // wait for the next update pulse, counting cycles from the last one
    task automatic tk(output int cnt);
        cnt = 1;
        @(posedge clk);
        while (upd !== 1'b1) begin
            @(posedge clk);
            cnt++;
        end
    endtask : tk
    // program both channels, then let two updates pass
    task automatic cfg(input logic [6:0] s1, input int g1, input logic [6:0] s2, input int g2);
        wr(mdsc_pkg::ADDR_CH1_SEL, 32'(s1), r);
        wr(mdsc_pkg::ADDR_CH2_SEL, 32'(s2), r);
        wr(mdsc_pkg::ADDR_CH1_GAIN, 32'(g1), r);
        wr(mdsc_pkg::ADDR_CH2_GAIN, 32'(g2), r);
        tk(n);
        tk(n);
    endtask : cfg
    task automatic t_scale;
        q.current_fb <= 16'sd4096;
        cfg(mdsc_pkg::DN_SPEED_FB, 0, mdsc_pkg::DN_CUR_FB, 1);
        chk(c1, 8'h80);
        chk(c2, 8'h90);
        q.current_fb <= 16'sd4915;
        q.current_cmd <= -16'sd4096;
        cfg(mdsc_pkg::DN_CUR_FB, 6, mdsc_pkg::DN_CUR_CMD, 6);
        chk(c1, xc(4915, 6));
        chk(c2, xc(-4096, 6));
    endtask : t_scale
    task automatic t_pos;
        q.droop <= 32'sd6400;
        q.speed_fb <= 32'sd2000;
        cfg(mdsc_pkg::DN_DROOP_LO, 5, mdsc_pkg::DN_SPEED_FB, 16);
        chk(c1, xc(6400, 5));
        chk(c2, xc(2000, 16));
        q.fb_pos <= 32'hFFFE_0000;
        q.pos_cmd <= 32'h0001_00F0;
        cfg(mdsc_pkg::DN_FBPOS_HI, 0, mdsc_pkg::DN_PCMD_LO, 0);
        chk(c1, xc(-2, 0));
        chk(c2, 8'h70);
        q.speed_fb <= 32'sd200;
        q.ctrl_out[1] <= 16'h0042;
        cfg(mdsc_pkg::DN_SPEED_FB, 256, 7'h55, 0);
        chk(c1, 8'h48);
        chk(c2, 8'hC2);
    endtask : t_pos
    task automatic t_bits;
        q.orient_done <= 1'b1;
        q.ctrl_in[0] <= 16'h0005;
        cfg(mdsc_pkg::DN_CTRL_OUT4, 0, mdsc_pkg::DN_CTRL_IN1, 0);
        chk(c1, xc(144, 0));
        chk(c2, 8'h85);
        q.droop <= 32'shFFFD_0000;
        q.pos_incr <= 32'sh0003_0000;
        cfg(mdsc_pkg::DN_DROOP_HI, 256, mdsc_pkg::DN_INCR_HI, 0);
        chk(c1, xc(-3, 256));
        chk(c2, xc(3, 0));
    endtask : t_bits
    task automatic t_meter;
        q.speed_fb <= 32'sd6000;
        q.load <= 16'sd4915;
        cfg(mdsc_pkg::DN_METER, 0, mdsc_pkg::DN_METER, 0);
        chk(c1, 8'hFF);
        chk(c2, 8'hFF);
        @(posedge clk);
        chk(mv, 9960);
        wr(mdsc_pkg::ADDR_SPEEDO_FS, 32'd12000, r);
        tk(n);
        tk(n);
        chk(c1, xc(6000 * 255 / 12000 - 128, 0));
    endtask : t_meter
    task automatic t_hold;
        tk(n);
        wr(mdsc_pkg::ADDR_CH1_GAIN, 32'd512, r);
        chk(c1, xc(-1, 0));
        tk(n);
        tk(n);
        chk(n, TICKS);
        chk(c1, xc(-1, 512));
    endtask : t_hold
    task automatic t_bus;
        logic [31:0] d;
        rd(mdsc_pkg::ADDR_SPEEDO_FS, d, r);
        chk(d, 32'd12000);
        rd(mdsc_pkg::ADDR_CH1_GAIN, d, r);
        chk(d, 32'd512);
        rd(mdsc_pkg::ADDR_STATUS, d, r);
        chk(d, 32'h0000_FF7E);
        wr(mdsc_pkg::ADDR_STATUS, 32'h0, r);
        chk(r, 2'h2);
        rd(8'h18, d, r);
        chk(r, 2'h2);
        chk(d, 32'h0);
    endtask : t_bus
    // verdict and end of run
    task automatic wrap_up;
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({c2, c1}, 16'h8080);
        rd(mdsc_pkg::ADDR_SPEEDO_FS, d0, r);
        chk(d0, 32'd6000);
        t_scale;
        t_pos;
        t_bits;
        t_meter;
        t_hold;
        t_bus;
        wrap_up;
    end
    // watchdog against a hung handshake
    initial begin
        #80000;
        n_mismatch++;
        wrap_up;
    end
endmodule : monitor_dac_data_scaler_test
